// file: hdl/phy_basic_control_status_regs.sv
// basic control and status registers with their serial management port
// assumes status inputs and nibble paths are on sys_clk; straps, mdc and mdio are pins
//
// Summary of operation
// RL1 - soft reset restores defaults, then self-clears
// RL2 - loopback returns transmit nibbles to receive path
// RL3 - speed bit: 1 is 100M, 0 is 10M
// RL4 - fiber mode forces speed to 1, read-only
// RL5 - autoneg enabled ignores speed and duplex bits
// RL6 - fiber forces autoneg enable 0; default 1
// RL7 - power down keeps management port alive
// RL8 - restart bit restarts negotiation, self-clears
// RL9 - duplex bit sets mode, reads resolved duplex
// RL10 - fiber duplex set by write or strap
// RL11 - ability bits are read-only constants
// RL12 - frames without preamble accepted; bit reads 1
// RL13 - manager sends 32 preamble bits after reset
// RL14 - manager leaves one idle bit between frames
// RL15 - autoneg complete bit shows negotiation finished
// RL16 - remote fault sticky, cleared by status read
// RL17 - link failure history reads 0 after fail
// RL18 - link status shows valid link
// RL19 - jabber bit shows jabber detected
// RL20 - extended capability reads constant 1
// RL21 - management address captured from straps at reset
// RL22 - speed, duplex, autoneg straps set defaults
// RL23 - reserved bits read zero, writes ignored
`timescale 1ns/1ps

module phy_basic_control_status_regs (
   input  wire logic       sys_clk_i,
   input  wire logic       resetn_i,
   input  wire logic       mdc_i,
   input  wire logic       mdio_i,
   output logic            mdio_o,
   output logic            mdio_oe_o,
   input  wire logic [4:0] management_address_strap_i,
   input  wire logic       speed_strap_i,
   input  wire logic       duplex_strap_i,
   input  wire logic       autoneg_strap_pin_i,
   input  wire logic       fiber_mode_i,
   input  wire logic       autoneg_done_i,
   input  wire logic       resolved_speed_i,
   input  wire logic       resolved_duplex_i,
   input  wire logic       remote_fault_i,
   input  wire logic       link_up_i,
   input  wire logic       link_fail_i,
   input  wire logic       jabber_i,
   input  wire logic [3:0] txd_i,
   input  wire logic [3:0] line_rxd_i,
   output logic [3:0]      rxd_o,
   output logic            loopback_o,
   output logic            speed_100_o,
   output logic            full_duplex_o,
   output logic            autoneg_en_o,
   output logic            autoneg_restart_o,
   output logic            power_down_o,
   output logic            soft_reset_o
);

   // ==========================================================
   // reset release
   // asserts at once, releases two clocks later
   logic rst_s1_q;
   logic rst_s2_q;

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // ==========================================================
   // state
   typedef struct packed {
      logic                      mdc_s1;
      logic                      mdc_s2;
      logic                      mdc_prev;
      logic                      mdio_s1;
      logic                      mdio_s2;
      logic [7:0]                strap_s1;
      logic [7:0]                strap_s2;
      logic [1:0]                strap_cnt;
      logic                      strap_done;
      logic [4:0]                phy_addr;
      logic                      strap_speed;
      logic                      strap_duplex;
      logic                      strap_an;
      logic                      loopback;
      logic                      speed;
      logic                      an_en;
      logic                      power_down;
      logic                      duplex;
      logic                      remote_fault;
      logic                      link_fail_hist;
      phy_bmcr_pkg::mgmt_state_t state;
      logic [4:0]                cnt;
      logic [15:0]               shreg;
      logic                      wr_ok;
      logic [4:0]                reg_sel;
      logic                      mdio_out;
      logic                      mdio_oe;
      logic                      soft_reset;
      logic                      an_restart;
      logic [3:0]                rxd;
      logic                      speed_out;
      logic                      duplex_out;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic        mdc_rise;
   logic        bit_in;
   logic        speed_eff;
   logic        an_eff;
   logic        duplex_rd;
   logic [12:0] hdr;
   logic [15:0] wdata;
   logic [15:0] ctrl_word;
   logic [15:0] status_word;
   logic        status_read;

   // ==========================================================
   // register select decode, shared by read and write
   function automatic logic is_ctrl_reg(input logic [4:0] sel);
      return sel == phy_bmcr_pkg::CTRL_REG_ADDR;
   endfunction : is_ctrl_reg

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;

      // pins pass two flip-flops before use
      s_d.mdc_s1   = mdc_i;
      s_d.mdc_s2   = s_q.mdc_s1;
      s_d.mdc_prev = s_q.mdc_s2;
      s_d.mdio_s1  = mdio_i;
      s_d.mdio_s2  = s_q.mdio_s1;
      s_d.strap_s1 = {management_address_strap_i, speed_strap_i, duplex_strap_i, autoneg_strap_pin_i};
      s_d.strap_s2 = s_q.strap_s1;

      // edge and data share the same two-stage delay
      mdc_rise = s_q.mdc_s2 & ~s_q.mdc_prev;
      bit_in   = s_q.mdio_s2;

      // effective control fields
      // fiber mode overrides stored speed and autoneg bits
      speed_eff = fiber_mode_i | s_q.speed;                                    // [RL4]
      an_eff    = ~fiber_mode_i & s_q.an_en;                                   // [RL6]
      duplex_rd = (an_eff && autoneg_done_i) ? resolved_duplex_i : s_q.duplex; // [RL9]

      ctrl_word = 16'h0000;                                                    // [RL23]
      ctrl_word[phy_bmcr_pkg::CTRL_LOOPBACK_BIT]   = s_q.loopback;
      ctrl_word[phy_bmcr_pkg::CTRL_SPEED_BIT]      = speed_eff;                // [RL3]
      ctrl_word[phy_bmcr_pkg::CTRL_AN_ENABLE_BIT]  = an_eff;
      ctrl_word[phy_bmcr_pkg::CTRL_POWER_DOWN_BIT] = s_q.power_down;
      ctrl_word[phy_bmcr_pkg::CTRL_DUPLEX_BIT]     = duplex_rd;

      status_word = {phy_bmcr_pkg::STATUS_ABILITIES, 4'h0,                      // [RL11] [RL23]
                     phy_bmcr_pkg::STATUS_PREAMBLE_SUP,                         // [RL12]
                     autoneg_done_i,                                            // [RL15]
                     s_q.remote_fault,                                          // [RL16]
                     s_q.link_fail_hist,                                        // [RL17]
                     link_up_i,                                                 // [RL18]
                     jabber_i,                                                  // [RL19]
                     phy_bmcr_pkg::STATUS_EXT_CAP};                             // [RL20]

      // header and write word include the bit sampled on this edge
      hdr         = {s_q.shreg[11:0], bit_in};
      wdata       = {s_q.shreg[14:0], bit_in};
      status_read = 1'b0;

      // one-cycle pulses
      s_d.soft_reset = 1'b0;
      s_d.an_restart = 1'b0;

      // straps taken once the synchronisers hold pin values
      if (!s_q.strap_done) begin
         if (s_q.strap_cnt == phy_bmcr_pkg::STRAP_SETTLE) begin
            s_d.strap_done   = 1'b1;
            s_d.phy_addr     = s_q.strap_s2[7:3];                               // [RL21]
            s_d.strap_speed  = s_q.strap_s2[2];                                 // [RL22]
            s_d.strap_duplex = s_q.strap_s2[1];
            s_d.strap_an     = s_q.strap_s2[0];
            s_d.speed        = s_q.strap_s2[2];
            s_d.duplex       = s_q.strap_s2[1];                                 // [RL10]
            s_d.an_en        = s_q.strap_s2[0];
         end else begin
            s_d.strap_cnt = s_q.strap_cnt + 2'h1;
         end
      end

      // management frame engine; preamble is optional
      if (mdc_rise) begin
         case (s_q.state)
            phy_bmcr_pkg::ST_IDLE: begin
               if (!bit_in) begin                                               // [RL12]
                  s_d.state = phy_bmcr_pkg::ST_HDR;
                  s_d.cnt   = 5'h00;
               end
            end
            phy_bmcr_pkg::ST_HDR: begin
               s_d.shreg = {s_q.shreg[14:0], bit_in};
               s_d.cnt   = s_q.cnt + 5'h01;
               if (s_q.cnt == phy_bmcr_pkg::HDR_LAST_BIT) begin
                  s_d.cnt     = 5'h00;
                  s_d.reg_sel = hdr[4:0];
                  s_d.wr_ok   = 1'b0;
                  s_d.state   = phy_bmcr_pkg::ST_WR;
                  if (hdr[12] && hdr[9:5] == s_q.phy_addr) begin
                     if (hdr[11:10] == phy_bmcr_pkg::OP_READ) begin
                        s_d.state = phy_bmcr_pkg::ST_RD_TA;
                        // data latched now, so a status read clears sticky bits here
                        if (is_ctrl_reg(hdr[4:0])) begin
                           s_d.shreg = ctrl_word;
                        end else if (hdr[4:0] == phy_bmcr_pkg::STATUS_REG_ADDR) begin
                           s_d.shreg   = status_word;
                           status_read = 1'b1;
                        end else begin
                           s_d.shreg = 16'h0000;
                        end
                     end else if (hdr[11:10] == phy_bmcr_pkg::OP_WRITE) begin
                        s_d.wr_ok = 1'b1;
                     end
                  end
               end
            end
            phy_bmcr_pkg::ST_RD_TA: begin
               // turnaround: drive zero for one bit
               s_d.mdio_oe  = 1'b1;
               s_d.mdio_out = 1'b0;
               s_d.cnt      = 5'h00;
               s_d.state    = phy_bmcr_pkg::ST_RD;
            end
            phy_bmcr_pkg::ST_RD: begin
               if (s_q.cnt == phy_bmcr_pkg::RD_BITS) begin
                  s_d.mdio_oe  = 1'b0;
                  s_d.mdio_out = 1'b0;
                  s_d.state    = phy_bmcr_pkg::ST_IDLE;
               end else begin
                  s_d.mdio_out = s_q.shreg[15];
                  s_d.shreg    = {s_q.shreg[14:0], 1'b0};
                  s_d.cnt      = s_q.cnt + 5'h01;
               end
            end
            phy_bmcr_pkg::ST_WR: begin
               // skipped frames count out their 18 bits here too
               s_d.shreg = wdata;
               s_d.cnt   = s_q.cnt + 5'h01;
               if (s_q.cnt == phy_bmcr_pkg::WR_LAST_BIT) begin
                  s_d.state = phy_bmcr_pkg::ST_IDLE;
                  if (s_q.wr_ok && is_ctrl_reg(s_q.reg_sel)) begin
                     if (wdata[phy_bmcr_pkg::CTRL_SOFT_RESET_BIT]) begin
                        s_d.soft_reset = 1'b1;                                  // [RL1]
                     end else begin
                        s_d.loopback   = wdata[phy_bmcr_pkg::CTRL_LOOPBACK_BIT];
                        s_d.power_down = wdata[phy_bmcr_pkg::CTRL_POWER_DOWN_BIT]; // [RL7]
                        s_d.duplex     = wdata[phy_bmcr_pkg::CTRL_DUPLEX_BIT];  // [RL10]
                        s_d.an_restart = wdata[phy_bmcr_pkg::CTRL_AN_RESTART_BIT]; // [RL8]
                        if (!fiber_mode_i) begin                                // [RL4] [RL6]
                           s_d.speed = wdata[phy_bmcr_pkg::CTRL_SPEED_BIT];
                           s_d.an_en = wdata[phy_bmcr_pkg::CTRL_AN_ENABLE_BIT];
                        end
                     end
                  end
               end
            end
            default: begin
               s_d.state   = phy_bmcr_pkg::ST_IDLE;
               s_d.mdio_oe = 1'b0;
            end
         endcase
      end

      // sticky status; a new event wins over the read clear
      s_d.remote_fault   = remote_fault_i | (s_q.remote_fault & ~status_read);   // [RL16]
      s_d.link_fail_hist = ~link_fail_i & (s_q.link_fail_hist | status_read);  // [RL17]

      // soft reset restores defaults from the taken straps
      if (s_d.soft_reset) begin                                                 // [RL1] [RL22]
         s_d.loopback       = phy_bmcr_pkg::CTRL_LOOPBACK_RST;
         s_d.power_down     = phy_bmcr_pkg::CTRL_POWER_DOWN_RST;
         s_d.speed          = s_q.strap_speed;
         s_d.duplex         = s_q.strap_duplex;
         s_d.an_en          = s_q.strap_an;
         s_d.remote_fault   = remote_fault_i;
         s_d.link_fail_hist = ~link_fail_i;
      end

      // resolved link mode
      s_d.speed_out  = an_eff ? resolved_speed_i : speed_eff;                  // [RL5]
      s_d.duplex_out = an_eff ? resolved_duplex_i : s_q.duplex;                // [RL5] [RL9]

      // receive nibble source
      s_d.rxd = s_q.loopback ? txd_i : line_rxd_i;                             // [RL2]
   end

   // ==========================================================
   // register
   always_ff @(posedge sys_clk_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         s_q                <= '0;
         s_q.state          <= phy_bmcr_pkg::ST_IDLE;
         // sync stages reset high: no false mdc edge
         s_q.mdc_s1         <= 1'b1;
         s_q.mdc_s2         <= 1'b1;
         s_q.mdc_prev       <= 1'b1;
         s_q.mdio_s1        <= 1'b1;
         s_q.mdio_s2        <= 1'b1;
         s_q.strap_speed    <= phy_bmcr_pkg::CTRL_SPEED_RST;
         s_q.strap_duplex   <= phy_bmcr_pkg::CTRL_DUPLEX_RST;
         s_q.strap_an       <= phy_bmcr_pkg::CTRL_AN_ENABLE_RST;
         s_q.loopback       <= phy_bmcr_pkg::CTRL_LOOPBACK_RST;
         s_q.speed          <= phy_bmcr_pkg::CTRL_SPEED_RST;
         s_q.an_en          <= phy_bmcr_pkg::CTRL_AN_ENABLE_RST;
         s_q.power_down     <= phy_bmcr_pkg::CTRL_POWER_DOWN_RST;
         s_q.duplex         <= phy_bmcr_pkg::CTRL_DUPLEX_RST;
         s_q.remote_fault   <= phy_bmcr_pkg::STATUS_RF_RST;
         s_q.link_fail_hist <= phy_bmcr_pkg::STATUS_LFH_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   assign mdio_o            = s_q.mdio_out;
   assign mdio_oe_o         = s_q.mdio_oe;
   assign rxd_o             = s_q.rxd;
   assign loopback_o        = s_q.loopback;
   assign speed_100_o       = s_q.speed_out;
   assign full_duplex_o     = s_q.duplex_out;
   // follows fiber mode without a clock of delay
   assign autoneg_en_o      = ~fiber_mode_i & s_q.an_en;
   assign autoneg_restart_o = s_q.an_restart;
   assign power_down_o      = s_q.power_down;
   assign soft_reset_o      = s_q.soft_reset;

endmodule : phy_basic_control_status_regs

// file: hdl/phy_bmcr_pkg.sv
// constants, field layouts and types for the basic control/status register pair
// assumes a 32-bit serial management frame with 16 data bits and a 5-bit device and register address
package phy_bmcr_pkg;

   // ==========================================================
   // register addresses
   localparam logic [4:0] CTRL_REG_ADDR   = 5'h00;
   localparam logic [4:0] STATUS_REG_ADDR = 5'h01;

   // ==========================================================
   // control register field positions
   localparam int CTRL_SOFT_RESET_BIT = 15;
   localparam int CTRL_LOOPBACK_BIT   = 14;
   localparam int CTRL_SPEED_BIT      = 13;
   localparam int CTRL_AN_ENABLE_BIT  = 12;
   localparam int CTRL_POWER_DOWN_BIT = 11;
   localparam int CTRL_AN_RESTART_BIT = 9;
   localparam int CTRL_DUPLEX_BIT     = 8;

   // control reset values, before the straps are taken
   localparam logic CTRL_LOOPBACK_RST   = 1'b0;
   localparam logic CTRL_SPEED_RST      = 1'b1;
   localparam logic CTRL_AN_ENABLE_RST  = 1'b1;
   localparam logic CTRL_POWER_DOWN_RST = 1'b0;
   localparam logic CTRL_DUPLEX_RST     = 1'b1;

   // ==========================================================
   // status register constant fields and reset values
   localparam logic [4:0] STATUS_ABILITIES   = 5'h0f;
   localparam logic       STATUS_PREAMBLE_SUP = 1'b1;
   localparam logic       STATUS_EXT_CAP     = 1'b1;
   localparam logic       STATUS_RF_RST      = 1'b0;
   localparam logic       STATUS_LFH_RST     = 1'b1;

   // ==========================================================
   // management frame layout
   localparam logic [1:0] OP_READ      = 2'h2;
   localparam logic [1:0] OP_WRITE     = 2'h1;
   localparam logic [4:0] HDR_LAST_BIT = 5'h0c;
   localparam logic [4:0] RD_BITS      = 5'h10;
   localparam logic [4:0] WR_LAST_BIT  = 5'h11;

   // cycles after reset release before the synchronised straps are valid
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_HDR   = 3'h1,
      ST_RD_TA = 3'h2,
      ST_RD    = 3'h3,
      ST_WR    = 3'h4
   } mgmt_state_t;

endpackage : phy_bmcr_pkg

// file: testbench/mdio_station_model.sv
// station manager model: management clock and data frames
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps

module mdio_station_model (
   input  wire logic        sys_clk_i,
   input  wire logic        mdio_i,
   output logic             mdc_o,
   output logic             mdio_o,
   output logic             mdio_oe_o,
   output logic [15:0]      rdata_o,
   output logic             rvalid_o
);
   // ==========================================
   // bit and frame tasks, clock still between frames
   initial begin
      mdc_o     = 1'b0;
      mdio_o    = 1'b0;
      mdio_oe_o = 1'b0;
      rdata_o   = 16'h0000;
      rvalid_o  = 1'b0;
   end

   // 4 clocks low, 4 high; sample at the rise
   task automatic mbit(input logic drv, input logic v, output logic s);
      @(negedge sys_clk_i);
      mdio_oe_o = drv;
      mdio_o    = drv ? v : ~v;
      repeat (3) @(negedge sys_clk_i);
      s     = mdio_i;
      mdc_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      mdc_o = 1'b0;
   endtask : mbit

   task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] ph, input logic [4:0] ra,
                        input logic [15:0] wd);
      logic [31:0] bits;
      logic [15:0] got;
      logic        s;
      logic        rd;
      rd   = (op == 2'h2);
      bits = {2'h1, op, ph, ra, 2'h2, wd};
      for (int i = 0; i < pre; i++) mbit(1'b1, 1'b1, s);
      for (int i = 31; i >= 0; i--) begin
         mbit(!(rd && i < 18), bits[i], s);
         if (i < 16) got[i] = s;
      end
      mbit(1'b0, 1'b1, s);
      if (rd) begin
         rdata_o  = got;
         rvalid_o = 1'b1;
         @(negedge sys_clk_i);
         rvalid_o = 1'b0;
      end
   endtask : frame
endmodule : mdio_station_model

// file: testbench/phy_basic_control_status_regs_properties.sv
// checker on the control outputs and receive nibble path of the register pair
// assumes one sys_clk domain and the active-low reset pin
`timescale 1ns/1ps

module phy_regs_checker (
   input wire logic       sys_clk_i,
   input wire logic       resetn_i,
   input wire logic       fiber_mode_i,
   input wire logic       resolved_speed_i,
   input wire logic       resolved_duplex_i,
   input wire logic [3:0] txd_i,
   input wire logic [3:0] line_rxd_i,
   input wire logic [3:0] rxd_o,
   input wire logic       loopback_o,
   input wire logic       speed_100_o,
   input wire logic       full_duplex_o,
   input wire logic       autoneg_en_o,
   input wire logic       autoneg_restart_o,
   input wire logic       power_down_o,
   input wire logic       soft_reset_o
);
   // ==========================================
   // settle counter past internal reset and strap capture
   logic [3:0] up_q;
   logic       ok;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) up_q <= 4'h0;
      else if (up_q != 4'hf) up_q <= up_q + 4'h1;
   end
   assign ok = (up_q == 4'hf);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   a_rxd_loop_path: assert property (ok && loopback_o && $past(loopback_o) |-> rxd_o == $past(txd_i))
      else $error("receive nibble does not follow transmit in loopback");
   a_rxd_line_path: assert property (ok && !loopback_o && !$past(loopback_o) |-> rxd_o == $past(line_rxd_i))
      else $error("receive nibble does not follow line");
   a_fiber_an_off: assert property (fiber_mode_i |-> !autoneg_en_o)
      else $error("autoneg enabled in fiber mode");
   a_fiber_speed_up: assert property (ok && $past(fiber_mode_i) |-> speed_100_o)
      else $error("speed not 100 in fiber mode");
   a_an_speed_follow: assert property (ok && $past(autoneg_en_o) |-> speed_100_o == $past(resolved_speed_i))
      else $error("speed ignores negotiated result");
   a_an_duplex_follow: assert property (ok && $past(autoneg_en_o) |-> full_duplex_o == $past(resolved_duplex_i))
      else $error("duplex ignores negotiated result");
   a_restart_one_shot: assert property (autoneg_restart_o |=> !autoneg_restart_o [*8])
      else $error("restart pulse not single");
   a_soft_reset_clear: assert property (soft_reset_o |=> !soft_reset_o ##1 (!loopback_o && !power_down_o))
      else $error("soft reset did not restore defaults");
endmodule : phy_regs_checker

bind phy_basic_control_status_regs phy_regs_checker u_phy_regs_checker (
   .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .fiber_mode_i(fiber_mode_i),
   .resolved_speed_i(resolved_speed_i), .resolved_duplex_i(resolved_duplex_i), .txd_i(txd_i),
   .line_rxd_i(line_rxd_i), .rxd_o(rxd_o), .loopback_o(loopback_o), .speed_100_o(speed_100_o),
   .full_duplex_o(full_duplex_o), .autoneg_en_o(autoneg_en_o), .autoneg_restart_o(autoneg_restart_o),
   .power_down_o(power_down_o), .soft_reset_o(soft_reset_o));

// file: testbench/tb.sv
// self-checking bench for the basic control and status register pair
// assumes the station model is the only manager on the data wire
`timescale 1ns/1ps

module tb;
   // ==========================================
   // pins, counters and expected-read queue
   logic        clk = 1'b0;
   logic        rstn, mdc, m_do, m_oe, d_do, d_oe, mdio, rvalid;
   logic        fiber, an_done, r_spd, r_dup, rfault, lfail, link, jab;
   logic        loop, spd, fdup, an_en, an_rst, pdown, srst;
   logic [3:0]  txd, lrxd, rxd;
   logic [4:0]  addr;
   logic [2:0]  strap;
   logic [15:0] rdata;
   logic [15:0] exp_q[$];
   int          err_count = 0;
   int          n_tests = 0;
   int          n_rst = 0;
   int          n_srst = 0;
   integer      seed = 32'h8f43;

   always #12.5 clk = ~clk;
   assign mdio = d_oe ? d_do : (m_oe ? m_do : 1'b1);

   phy_basic_control_status_regs u_phy_basic_control_status_regs (
      .sys_clk_i(clk), .resetn_i(rstn), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(d_do), .mdio_oe_o(d_oe),
      .management_address_strap_i(addr), .speed_strap_i(strap[2]), .duplex_strap_i(strap[1]),
      .autoneg_strap_pin_i(strap[0]), .fiber_mode_i(fiber), .autoneg_done_i(an_done),
      .resolved_speed_i(r_spd), .resolved_duplex_i(r_dup), .remote_fault_i(rfault),
      .link_up_i(link), .link_fail_i(lfail), .jabber_i(jab), .txd_i(txd), .line_rxd_i(lrxd),
      .rxd_o(rxd), .loopback_o(loop), .speed_100_o(spd), .full_duplex_o(fdup), .autoneg_en_o(an_en),
      .autoneg_restart_o(an_rst), .power_down_o(pdown), .soft_reset_o(srst));

   mdio_station_model u_mdio_station_model (
      .sys_clk_i(clk), .mdio_i(mdio), .mdc_o(mdc), .mdio_o(m_do), .mdio_oe_o(m_oe),
      .rdata_o(rdata), .rvalid_o(rvalid));

   task automatic fail(input string msg);
      $display("[ERR] %0t %s", $time, msg);
      err_count++;
   endtask : fail

   task automatic chk(input logic [15:0] got, input logic [15:0] ev);
      n_tests++;
      if (got !== ev) fail($sformatf("got %h expected %h", got, ev));
   endtask : chk

   function automatic logic [15:0] ports();
      return 16'({loop, pdown, spd, fdup, an_en});
   endfunction : ports

   task automatic rd(input int pre, input logic [4:0] ph, input logic [4:0] ra, input logic [15:0] ev);
      exp_q.push_back(ev);
      u_mdio_station_model.frame(pre, 2'h2, ph, ra, 16'h0000);
   endtask : rd

   task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
      u_mdio_station_model.frame(0, 2'h1, addr, ra, wd);
   endtask : wr

   task automatic final_report();
      if (exp_q.size() != 0) fail("reads missing");
      if (err_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   always @(posedge clk) begin
      if (an_rst === 1'b1) n_rst++;
      if (srst === 1'b1) n_srst++;
      if (rvalid === 1'b1) begin
         n_tests++;
         if (exp_q.size() == 0) fail("read without note");
         else begin
            if (rdata !== exp_q[0]) fail($sformatf("read %h expected %h", rdata, exp_q[0]));
            void'(exp_q.pop_front());
         end
      end
   end

   initial begin
      repeat (100000) @(posedge clk);
      fail("timeout");
      final_report();
   end

   initial begin
      {rstn, fiber, an_done, r_spd, r_dup, rfault, lfail, link, jab} = 9'h0;
      addr = 5'($random(seed));
      strap = 3'h5;
      txd  = 4'h0;
      lrxd = 4'h0;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (12) @(negedge clk);
      rd(32, addr, 5'h00, 16'h3000);
      rd(0, addr, 5'h01, 16'h7849);
      {rfault, lfail, link, jab, an_done} = 5'h1f;
      @(negedge clk);
      {rfault, lfail} = 2'h0;
      rd(0, addr, 5'h01, 16'h7877);
      rd(0, addr, 5'h01, 16'h786f);
      wr(5'h00, 16'h4dff);
      rd(0, addr, 5'h00, 16'h4900);
      chk(ports(), 16'h001a);
      for (int i = 0; i < 8; i++) begin
         txd  = 4'($random(seed));
         lrxd = ~txd;
         @(negedge clk);
         chk(16'(rxd), 16'(txd));
      end
      {r_spd, r_dup} = 2'h3;
      wr(5'h00, 16'h1000);
      rd(0, addr, 5'h00, 16'h1100);
      chk(ports(), 16'h0007);
      lrxd = 4'($random(seed));
      @(negedge clk);
      chk(16'(rxd), 16'(lrxd));
      wr(5'h00, 16'h1200);
      chk(16'(n_rst), 16'h0001);
      rd(0, addr, 5'h00, 16'h1100);
      fiber = 1'b1;
      wr(5'h00, 16'h1000);
      rd(0, addr, 5'h00, 16'h2000);
      chk(ports(), 16'h0004);
      wr(5'h00, 16'h0100);
      rd(0, addr, 5'h00, 16'h2100);
      chk(ports(), 16'h0006);
      u_mdio_station_model.frame(0, 2'h1, addr ^ 5'h01, 5'h00, 16'h4000);
      rd(0, addr ^ 5'h01, 5'h00, 16'hffff);
      rd(0, addr, 5'h1f, 16'h0000);
      chk(ports(), 16'h0006);
      {fiber, an_done, link, jab} = 4'h0;
      wr(5'h00, 16'h4800);
      {rfault, lfail} = 2'h3;
      @(negedge clk);
      {rfault, lfail} = 2'h0;
      wr(5'h00, 16'h8000);
      chk(16'(n_srst), 16'h0001);
      rd(0, addr, 5'h00, 16'h3000);
      rd(0, addr, 5'h01, 16'h7849);
      chk(ports(), 16'h0007);
      @(negedge clk);
      rstn  = 1'b0;
      strap = 3'h2;
      addr  = ~addr;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (12) @(negedge clk);
      rd(32, addr, 5'h00, 16'h0100);
      rd(0, addr, 5'h01, 16'h7849);
      chk(ports(), 16'h0002);
      final_report();
   end
endmodule : tb
